/* common/mcs_params.svh */
// Purpose: timing counts and field positions of the measurement cycle sequencer
// Assumes: included by the design file and the assertion file
// Notes:   definitions only
`ifndef MCS_PARAMS_SVH
`define MCS_PARAMS_SVH
`define MCS_CFG_W          16
`define MCS_CNT_MSB        9
`define MCS_CNT_LSB        7
`define MCS_T2E_BIT        10
`define MCS_CODE_W         6
`define MCS_SHIFT_MAX      31
`define MCS_SHIFT_SPEC     20
`define MCS_CNT_RST        3'h0
`define MCS_PRECOMP_RST    6'h00
`define MCS_SHIFT_RST      6'h00
`define MCS_REP_RST        8'h00
`define MCS_SEL_RST        5'h01
`endif

/* common/mcs_pkg.sv */
// Purpose: types of the measurement cycle sequencer
// Assumes: mcs_params.svh holds the numbers
// Notes:   input selector codes are one-hot
package mcs_pkg;
    typedef enum logic [4:0] {
        MCS_SEL_AZ     = 5'h01,
        MCS_SEL_DIODE  = 5'h02,
        MCS_SEL_BRTEMP = 5'h04,
        MCS_SEL_THERM  = 5'h08,
        MCS_SEL_BRIDGE = 5'h10
    } mcs_sel_t;
    typedef enum logic [1:0] {
        MCS_TSRC_DIODE  = 2'h0,
        MCS_TSRC_BRIDGE = 2'h1,
        MCS_TSRC_THERM  = 2'h2,
        MCS_TSRC_NONE   = 2'h3
    } mcs_tsrc_t;
endpackage : mcs_pkg

/* common/mcs_step_if.sv */
// Purpose: step request/answer carrier between sequencer and selector decoder
// Assumes: one clock
// Notes:   none
`timescale 1ns/1ps
interface mcs_step_if;
    import mcs_pkg::*;
    logic     az;
    logic     temp;
    mcs_tsrc_t tsrc;
    mcs_sel_t sel;
    modport seq (output az, output temp, output tsrc, input sel);
    modport dec (input az, input temp, input tsrc, output sel);
endinterface : mcs_step_if

/* hw/mcs_cycle_seq.sv */
// Purpose: sequences the input selector through start routine and measurement cycle
// Assumes: conversion done pulse from the converter on core_clk_i
// Notes:   the correction controller starts each cycle through its go pulse; conversion done advances the steps
// Overview of operation
// - six-bit analog offset precompensation code output
// - zero shift code accepted -31..31
// - digital offset cancel flagged for correction
// - fixed selector order over auto-zero, bridge and the two chosen temperature inputs
// - auto-zero shorts channel input
// - controller go pulse starts each cycle; conversion done paces each step
// - count from config bits 9:7
// - enable bit adds secondary temperature
// - start routine: bridge and auto-zero
// - start adds main temperature if enabled
// - only main temperature feeds correction
`timescale 1ns/1ps
`include "mcs_params.svh"
module mcs_cycle_seq
    import mcs_pkg::*;
(
    input  wire logic                     core_clk_i,
    input  wire logic                     reset_i,
    input  wire logic [`MCS_CFG_W-1:0]    cycle_config_word_i,
    input  wire logic [`MCS_CODE_W-1:0]   analog_offset_precomp_i,
    input  wire logic [`MCS_CODE_W-1:0]   zero_shift_steps_i,
    input  wire logic                     main_temp_enable_i,
    input  wire logic [1:0]               main_temp_source_i,
    input  wire logic [1:0]               second_temp_source_i,
    input  wire logic                     go_i,
    input  wire logic                     conv_done_i,
    output logic [4:0]                    input_selector_o,
    output logic                          conv_start_o,
    output logic                          busy_o,
    output logic                          start_done_o,
    output logic                          temp_corr_valid_o,
    output logic                          second_temp_valid_o,
    output logic                          bridge_valid_o,
    output logic                          digital_offset_cancel_o,
    output logic [`MCS_CODE_W-1:0]        analog_offset_precomp_o,
    output logic [`MCS_CODE_W-1:0]        zero_shift_steps_o,
    output logic                          zero_shift_in_spec_o
);
    typedef enum logic [5:0] {
        ST_IDLE   = 6'h01,
        ST_AZ     = 6'h02,
        ST_BRIDGE = 6'h04,
        ST_TAZ    = 6'h08,
        ST_TEMP   = 6'h10,
        ST_T2     = 6'h20
    } mcs_state_t;

    mcs_state_t state_q, state_d;
    logic       done_q;
    logic       wait_q;
    logic [7:0] rep_q;
    logic [4:0] sel_q;
    logic       conv_q, tv_q, t2v_q, bv_q, dc_q, spec_q;
    logic [5:0] pre_q, zs_q;

    mcs_step_if st ();
    mcs_sel_decode u_dec (.st(st));

    wire [2:0] cnt_code = cycle_config_word_i[`MCS_CNT_MSB:`MCS_CNT_LSB];
    wire [7:0] rep_last = 8'(({1'b0, 8'h01} << cnt_code) - 9'h001);
    wire       t2_en = cycle_config_word_i[`MCS_T2E_BIT];
    wire [5:0] zs_clamped = (zero_shift_steps_i == 6'h20) ? 6'h21 : zero_shift_steps_i;
    wire signed [5:0] zs_s = signed'(zs_clamped);
    wire       zs_spec = (zs_s <= 6'sh14) && (zs_s >= -6'sh14);
    wire       step_go = (state_q == ST_IDLE) ? go_i : (wait_q && conv_done_i);
    wire       in_start = !done_q;
    wire       rep_done = (rep_q == rep_last) || in_start;
    wire       cycle_go = (state_q == ST_IDLE) && go_i;
    wire       start_step = step_go && (state_d != ST_IDLE);
    wire       leave_cycle = (state_q != ST_IDLE) && (state_d == ST_IDLE);
    wire       bridge_done = (state_q == ST_BRIDGE) && step_go;
    wire       temp_done = (state_q == ST_TEMP) && step_go;
    wire       t2_done = (state_q == ST_T2) && step_go;

    // secondary step, with or without main temperature
    mcs_state_t after_main;
    assign after_main = (t2_en && !in_start) ? ST_T2 : ST_IDLE;

    // idle parks on the shorted input
    assign st.az     = (state_q == ST_IDLE) || (state_q == ST_AZ) || (state_q == ST_TAZ);
    assign st.temp   = (state_q == ST_TAZ) || (state_q == ST_TEMP) || (state_q == ST_T2);
    assign st.tsrc   = mcs_tsrc_t'((state_q == ST_T2) ? second_temp_source_i : main_temp_source_i);

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE:   if (go_i) state_d = ST_AZ;
            ST_AZ:     if (step_go) state_d = ST_BRIDGE;
            ST_BRIDGE: if (step_go && rep_done) state_d = main_temp_enable_i ? ST_TAZ : after_main;
                       else if (step_go) state_d = ST_AZ;
            ST_TAZ:    if (step_go) state_d = ST_TEMP;
            ST_TEMP:   if (step_go) state_d = after_main;
            ST_T2:     if (step_go) state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            done_q <= 1'h0;
        end else if (leave_cycle) begin
            done_q <= 1'h1;
        end
    end

    // Busy from the first step start until the last step is answered
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            wait_q <= 1'h0;
        end else if (step_go) begin
            wait_q <= (state_d != ST_IDLE);
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            rep_q <= `MCS_REP_RST;
        end else if (cycle_go) begin
            rep_q <= `MCS_REP_RST;
        end else if (bridge_done) begin
            rep_q <= rep_q + 8'h01;
        end
    end

    // Selector settles one cycle after the step state
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            sel_q <= `MCS_SEL_RST;
        end else begin
            sel_q <= st.sel;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            conv_q <= 1'h0;
        end else begin
            conv_q <= start_step;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            bv_q <= 1'h0;
        end else begin
            bv_q <= bridge_done;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            dc_q <= 1'h0;
        end else begin
            dc_q <= bridge_done;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            tv_q <= 1'h0;
        end else begin
            tv_q <= temp_done;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            t2v_q <= 1'h0;
        end else begin
            t2v_q <= t2_done;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            pre_q <= `MCS_PRECOMP_RST;
        end else begin
            pre_q <= analog_offset_precomp_i;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            zs_q <= `MCS_SHIFT_RST;
        end else begin
            zs_q <= zs_clamped;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            spec_q <= 1'h0;
        end else begin
            spec_q <= zs_spec;
        end
    end

    assign input_selector_o        = sel_q;
    assign conv_start_o            = conv_q;
    assign busy_o                  = wait_q;
    assign start_done_o            = done_q;
    assign temp_corr_valid_o       = tv_q;
    assign second_temp_valid_o     = t2v_q;
    assign bridge_valid_o          = bv_q;
    assign digital_offset_cancel_o = dc_q;
    assign analog_offset_precomp_o = pre_q;
    assign zero_shift_steps_o      = zs_q;
    assign zero_shift_in_spec_o    = spec_q;
endmodule : mcs_cycle_seq

/* hw/mcs_sel_decode.sv */
// Purpose: maps a cycle step to the input selector code
// Assumes: combinational
// Notes:   none
`timescale 1ns/1ps
module mcs_sel_decode
    import mcs_pkg::*;
(
    mcs_step_if.dec st
);
    wire mcs_sel_t temp_sel;
    assign temp_sel = (st.tsrc == MCS_TSRC_BRIDGE) ? MCS_SEL_BRTEMP :
                      (st.tsrc == MCS_TSRC_THERM)  ? MCS_SEL_THERM  : MCS_SEL_DIODE;
    assign st.sel = st.az ? MCS_SEL_AZ : (st.temp ? temp_sel : MCS_SEL_BRIDGE);
endmodule : mcs_sel_decode

/* verif/mcs_afe_model.sv */
// Purpose: converter stand-in that answers each step
// Assumes: lat_i above zero
// Notes:   done pulses lat_i+1 cycles after start
`timescale 1ns/1ps
module mcs_afe_model (
    input  wire logic       core_clk_i,
    input  wire logic       reset_i,
    input  wire logic       conv_start_i,
    input  wire logic [3:0] lat_i,
    output logic            conv_done_o
);
    logic [3:0] cnt_q;
    logic       run_q;
    assign conv_done_o = run_q && cnt_q == 4'h0;
    always_ff @(posedge core_clk_i) begin
        if (reset_i || conv_start_i) cnt_q <= lat_i;
        else if (cnt_q != 4'h0) cnt_q <= cnt_q - 4'h1;
        if (reset_i || conv_start_i) run_q <= conv_start_i;
        else if (cnt_q == 4'h0) run_q <= 1'h0;
    end
endmodule : mcs_afe_model

/* verif/mcs_cycle_seq_assertions.sv */
// Purpose: port checks of the cycle sequencer
// Assumes: one clock, synchronous reset
// Notes:   bound into mcs_cycle_seq
`timescale 1ns/1ps
`include "mcs_params.svh"
module mcs_cycle_seq_chk
    import mcs_pkg::*;
(
    input wire logic        core_clk_i,
    input wire logic        reset_i,
    input wire logic [15:0] cycle_config_word_i,
    input wire logic [4:0]  input_selector_o,
    input wire logic        conv_start_o,
    input wire logic        busy_o,
    input wire logic        start_done_o,
    input wire logic        temp_corr_valid_o,
    input wire logic        second_temp_valid_o,
    input wire logic        bridge_valid_o,
    input wire logic        digital_offset_cancel_o,
    input wire logic [5:0]  zero_shift_steps_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (reset_i);
    sequence s_brg; $rose(input_selector_o == MCS_SEL_BRIDGE); endsequence
    property p_clamp; zero_shift_steps_o != 6'h20; endproperty
    a_clamp: assert property (p_clamp) else $error("shift code -32");
    property p_hot; $onehot(input_selector_o); endproperty
    a_hot: assert property (p_hot) else $error("selector not one-hot");
    property p_start; conv_start_o |-> busy_o ##1 !conv_start_o; endproperty
    a_start: assert property (p_start) else $error("step start");
    property p_az; s_brg |-> $past(input_selector_o) == MCS_SEL_AZ; endproperty
    a_az: assert property (p_az) else $error("bridge without auto-zero");
    property p_brg; bridge_valid_o |-> input_selector_o == MCS_SEL_BRIDGE && digital_offset_cancel_o; endproperty
    a_brg: assert property (p_brg) else $error("bridge result");
    property p_corr; temp_corr_valid_o |-> !second_temp_valid_o && !bridge_valid_o; endproperty
    a_corr: assert property (p_corr) else $error("temperature result");
    property p_t2; second_temp_valid_o |-> cycle_config_word_i[`MCS_T2E_BIT] && start_done_o; endproperty
    a_t2: assert property (p_t2) else $error("second temperature");
    property p_done; start_done_o |=> start_done_o; endproperty
    a_done: assert property (p_done) else $error("start done dropped");
endmodule : mcs_cycle_seq_chk
bind mcs_cycle_seq mcs_cycle_seq_chk u_chk (
    .core_clk_i              (core_clk_i),
    .reset_i                 (reset_i),
    .cycle_config_word_i     (cycle_config_word_i),
    .input_selector_o        (input_selector_o),
    .conv_start_o            (conv_start_o),
    .busy_o                  (busy_o),
    .start_done_o            (start_done_o),
    .temp_corr_valid_o       (temp_corr_valid_o),
    .second_temp_valid_o     (second_temp_valid_o),
    .bridge_valid_o          (bridge_valid_o),
    .digital_offset_cancel_o (digital_offset_cancel_o),
    .zero_shift_steps_o      (zero_shift_steps_o)
);

/* verif/mcs_cycle_seq_bench.sv */
// Purpose: self-checking bench of the cycle sequencer
// Assumes: inputs change on the falling edge
// Notes:   cycle length checked for every count code
`timescale 1ns/1ps
module mcs_cycle_seq_bench import mcs_pkg::*; ;
    logic       clk = 1'h0, rst = 1'h1, go = 1'h0, men = 1'h0, cst, busy, sd, tcv, stv, cdone, spec, bv, dco;
    logic [15:0] cfg = 16'h0000;
    logic [5:0] pre = 6'h00, zsh = 6'h00, pre_o, zsh_o;
    logic [4:0] sel, psel;
    logic [3:0] lat = 4'h3;
    int         bad_count = 0, checks = 0, cyc = 0, nb, nt, ns, nv;
    // Codes driven beside their expected shift output and in-spec flag
    logic [5:0] zi [5] = '{6'h14, 6'h15, 6'h20, 6'h2c, 6'h1f};
    logic [5:0] zo [5] = '{6'h14, 6'h15, 6'h21, 6'h2c, 6'h1f};
    logic       sp [5] = '{1'h1, 1'h0, 1'h0, 1'h1, 1'h0};
    always #2.5 clk = ~clk;
    mcs_cycle_seq dut (.core_clk_i(clk), .reset_i(rst), .cycle_config_word_i(cfg), .analog_offset_precomp_i(pre),
        .zero_shift_steps_i(zsh), .main_temp_enable_i(men), .main_temp_source_i(2'h0), .second_temp_source_i(2'h2),
        .go_i(go), .conv_done_i(cdone), .input_selector_o(sel), .conv_start_o(cst), .busy_o(busy),
        .start_done_o(sd), .temp_corr_valid_o(tcv), .second_temp_valid_o(stv), .bridge_valid_o(bv),
        .digital_offset_cancel_o(dco), .analog_offset_precomp_o(pre_o), .zero_shift_steps_o(zsh_o),
        .zero_shift_in_spec_o(spec));
    mcs_afe_model afe (.core_clk_i(clk), .reset_i(rst), .conv_start_i(cst), .lat_i(lat), .conv_done_o(cdone));
    task automatic chk(input logic ok, input string m);
        checks++;
        if (ok !== 1'h1) begin
            bad_count++;
            $display("ERROR %0t %s", $time, m);
        end
    endtask : chk
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : end_of_test
    // One go pulse, then count bridge steps and result pulses until idle
    task automatic run(input int k, input logic t2, input logic me);
        int idle = 0;
        cfg = {5'h00, t2, k[2:0], 7'h00};
        men = me;
        go = 1'h1;
        nb = 0;
        nt = 0;
        ns = 0;
        nv = 0;
        @(negedge clk) go = 1'h0;
        while (idle < 8) begin
            @(negedge clk);
            idle = (busy === 1'h0) ? idle + 1 : 0;
            nb += (sel === MCS_SEL_BRIDGE && psel !== MCS_SEL_BRIDGE);
            nt += (tcv === 1'h1);
            ns += (stv === 1'h1);
            nv += (bv === 1'h1 && dco === 1'h1);
            psel = sel;
            cyc++;
            if (cyc == 20000) begin
                bad_count++;
                end_of_test();
            end
        end
        $display("cycle test %0d done", k);
    endtask : run
    initial begin
        repeat (8) @(negedge clk);
        chk(sel === MCS_SEL_AZ && busy === 1'h0 && sd === 1'h0, "reset state");
        rst = 1'h0;
        $display("reset test done");
        for (int i = 0; i < 5; i++) begin
            zsh = zi[i];
            pre = ~zi[i];
            repeat (2) @(negedge clk);
            chk(pre_o === ~zi[i] && zsh_o === zo[i] && spec === sp[i], "codes");
        end
        $display("code test done");
        run(3, 1'h1, 1'h1);
        chk(nb == 1 && nt == 1 && ns == 0 && sd === 1'h1, "start routine");
        chk(nv == 1, "start bridge result");
        for (int k = 0; k < 8; k++) begin
            lat = 4'(k + 1);
            run(k, k[0], k[1]);
            chk(nb == (1 << k) && nt == k[1] && ns == k[0], "cycle counts");
            chk(nv == (1 << k), "bridge results");
        end
        // Reset in the middle of a cycle, then the start routine must run again
        cfg = 16'h0100;
        go = 1'h1;
        @(negedge clk) go = 1'h0;
        repeat (12) @(negedge clk);
        chk(busy === 1'h1 && sd === 1'h1, "busy before reset");
        rst = 1'h1;
        repeat (8) @(negedge clk);
        chk(sel === MCS_SEL_AZ && busy === 1'h0 && sd === 1'h0 && cst === 1'h0, "mid-run reset");
        rst = 1'h0;
        run(2, 1'h1, 1'h0);
        chk(nb == 1 && nv == 1 && ns == 0 && sd === 1'h1, "start routine after reset");
        $display("mid-run reset test done");
        end_of_test();
    end
endmodule : mcs_cycle_seq_bench
